//--- hmr_pkg.sv
// Shared constants and carrier types of the hypervisor region limit block.
package hmr_pkg;

  // Coprocessor encodings of the hypervisor region registers.
  localparam logic [3:0] HMR_CP_NUM = 4'hF;
  localparam logic [3:0] HMR_CRN_REGION = 4'h6;
  localparam logic [2:0] HMR_OPC1_HYP = 3'h4;
  localparam logic [2:0] HMR_OPC2_HYP = 3'h1;
  localparam logic [3:0] HMR_CRM_LIMIT = 4'h3;
  localparam logic [3:0] HMR_CRM_SELECT = 4'h2;
  localparam logic [3:0] HMR_CRM_ENABLE = 4'h1;
  localparam logic [1:0] HMR_DIR_OPC1_HI = 2'h2;
  localparam logic [0:0] HMR_DIR_CRM_HI = 1'h1;
  localparam logic [1:0] HMR_DIR_OPC2_LO = 2'h1;
  localparam logic [3:0] HMR_CRN_IDENT = 4'h0;
  localparam logic [2:0] HMR_OPC1_IDENT = 3'h0;
  localparam logic [2:0] HMR_OPC2_IDENT = 3'h4;
  localparam logic [3:0] HMR_CRM_IDENT = 4'h0;

  // Field positions and fixed patterns.
  localparam int HMR_LIMIT_LSB = 6;
  localparam logic [5:0] HMR_LIMIT_LOW_ONES = 6'h3F;
  localparam logic [5:0] HMR_BASE_LOW_ZEROS = 6'h00;
  localparam int HMR_ATTR_LSB = 1;
  localparam int HMR_EN_BIT = 0;
  localparam int HMR_IDENT_COUNT_LSB = 8;
  localparam int HMR_ATTR_FIELD_W = 8;

  // Region counts and index width.
  localparam int HMR_IDX_W = 5;
  localparam int HMR_DEPTH = 32;
  localparam logic [5:0] HMR_NUM_HYP_REGIONS = 6'h18;
  localparam logic [7:0] HMR_NUM_EL1_REGIONS = 8'h10;
  localparam logic [31:0] HMR_IMPL_MASK = 32'((64'h1 << HMR_NUM_HYP_REGIONS) - 64'h1);

  // Reset values.
  localparam logic [HMR_IDX_W-1:0] HMR_SEL_RESET = 5'h00;
  localparam logic [31:0] HMR_EN_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    HMR_USER_LEVEL = 2'b00,
    HMR_KERNEL_LEVEL = 2'b01,
    HMR_HYPERVISOR_LEVEL = 2'b10
  } hmr_level_e;

  typedef enum logic [1:0] {
    HMR_RESP_OK = 2'b00,
    HMR_RESP_UNDEF = 2'b01,
    HMR_RESP_TRAP = 2'b10
  } hmr_resp_e;

  typedef enum logic [2:0] {
    HMR_TGT_NONE = 3'b000,
    HMR_TGT_LIM_IND = 3'b001,
    HMR_TGT_LIM_DIR = 3'b010,
    HMR_TGT_SELECT = 3'b011,
    HMR_TGT_ENABLE = 3'b100,
    HMR_TGT_IDENT = 3'b101
  } hmr_tgt_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] coproc;
    logic [2:0] opc1;
    logic [2:0] opc2;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [31:0] wdata;
    logic [1:0] level;
  } hmr_req_s;

  typedef struct packed {
    logic trap_general_exceptions;
    logic trap_bit_six;
    logic trap_bit_ten;
  } hmr_ctrl_s;

  typedef struct packed {
    logic valid;
    hmr_resp_e kind;
    logic [31:0] rdata;
  } hmr_resp_s;

  typedef struct packed {
    logic [25:0] limit;
    logic [2:0] attribute_index;
  } hmr_limit_s;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [HMR_IDX_W-1:0] region;
    logic [25:0] base;
  } hmr_lookup_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] attr;
  } hmr_hit_s;

endpackage

//--- hmr_limit_mem.sv
// Limit and attribute storage for the hypervisor regions, two registered read ports.
`timescale 1ns/1ps
module hmr_limit_mem
  import hmr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic we_in,
  input wire logic [HMR_IDX_W-1:0] addr_a_in,
  input wire hmr_limit_s wdata_in,
  input wire logic [HMR_IDX_W-1:0] addr_b_in,
  output hmr_limit_s rdata_a_out,
  output hmr_limit_s rdata_b_out
);

  // No reset: limit and attribute contents are undefined after reset.
  hmr_limit_s mem [HMR_DEPTH];

  always_ff @(posedge clk_sys_in)
  begin
    if (we_in)
    begin
      mem[addr_a_in] <= wdata_in;
    end
    rdata_a_out <= mem[addr_a_in];
    rdata_b_out <= mem[addr_b_in];
  end

endmodule

//--- hmr_region_match.sv
// Address compare and attribute pick for one hypervisor region.
`timescale 1ns/1ps
module hmr_region_match
  import hmr_pkg::*;
(
  input wire logic [31:0] addr_in,
  input wire logic [25:0] base_in,
  input wire hmr_limit_s limit_in,
  input wire logic enable_in,
  input wire logic [31:0] attr_low_in,
  input wire logic [31:0] attr_high_in,
  output logic hit_out,
  output logic [7:0] attr_out
);

  logic [31:0] lo_addr;
  logic [31:0] hi_addr;
  logic [31:0] table_word;

  always_comb
  begin
    lo_addr = {base_in, HMR_BASE_LOW_ZEROS};
    hi_addr = {limit_in.limit, HMR_LIMIT_LOW_ONES}; // R1
    hit_out = enable_in && (addr_in >= lo_addr) && (addr_in <= hi_addr); // R19
    table_word = limit_in.attribute_index[2] ? attr_high_in : attr_low_in; // R2
    attr_out = table_word[limit_in.attribute_index[1:0] * HMR_ATTR_FIELD_W +: HMR_ATTR_FIELD_W]; // R2
  end

endmodule

//--- hmr_top.sv
// Hypervisor region limit, selector, enable alias and region count registers.
// Contract
// [R1] Limit is stored bits plus six ones.
// [R2] Attribute index picks one of eight fields.
// [R3] Bit 0 enables region, resets to zero.
// [R4] Limit, index undefined at reset; bits 5:4 zero.
// [R5] Indirect limit decoded at its fixed encoding.
// [R6] Hypervisor level only; lower levels refused.
// [R7] Trap bit six traps indirect kernel accesses.
// [R8] Thirty-two directly addressed limit registers.
// [R9] Direct index spread over opcodes and register.
// [R10] Unimplemented direct indices are unallocated.
// [R11] Trap bit ten traps direct kernel accesses.
// [R12] Selector bits 7:0, upper bits zero; the code keeps only bits 4:0.
// [R13] Software writes only implemented region numbers.
// [R14] Selector picks region for indirect access.
// [R15] Count register reports kernel regions 15:8.
// [R16] Regions unified, no split instruction/data.
// [R17] Indirect limit follows current selector value.
// [R18] Enable alias mirrors bits, unimplemented read zero.
// [R19] Hit when base <= address <= limit.
`timescale 1ns/1ps
module hmr_top
  import hmr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire hmr_req_s req_in,
  input wire hmr_ctrl_s ctrl_in,
  input wire logic [31:0] attr_low_in,
  input wire logic [31:0] attr_high_in,
  input wire hmr_lookup_s lookup_in,
  output hmr_resp_s resp_out,
  output hmr_hit_s hit_out,
  output logic [31:0] region_enable_out
);

  typedef struct packed {
    logic [HMR_IDX_W-1:0] sel;
    logic [31:0] en;
    logic s1_valid;
    logic s1_read;
    hmr_resp_e s1_kind;
    hmr_tgt_e s1_tgt;
    logic [HMR_IDX_W-1:0] s1_idx;
    logic l1_valid;
    logic [31:0] l1_addr;
    logic [25:0] l1_base;
    logic [HMR_IDX_W-1:0] l1_region;
    hmr_resp_s resp;
    hmr_hit_s hit;
  } hmr_state_s;

  hmr_state_s st;
  hmr_state_s next_st;
  logic [1:0] rst_sync;
  logic rst_ok;
  hmr_tgt_e tgt;
  hmr_resp_e kind;
  logic [HMR_IDX_W-1:0] idx;
  logic is_direct;
  logic [HMR_IDX_W-1:0] dir_idx;
  logic mem_we;
  hmr_limit_s mem_wdata;
  hmr_limit_s mem_q_a;
  hmr_limit_s mem_q_b;
  logic match_hit;
  logic [7:0] match_attr;

  // The reset is released through two flops so no flop leaves reset on a ragged edge.
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_ok = rst_sync[1];

  // Decode of the coprocessor encoding.
  always_comb
  begin
    dir_idx = {req_in.opc1[0], req_in.crm[2:0], req_in.opc2[2]}; // R9
    is_direct = (req_in.coproc == HMR_CP_NUM) && (req_in.crn == HMR_CRN_REGION)
      && (req_in.opc1[2:1] == HMR_DIR_OPC1_HI) && (req_in.crm[3] == HMR_DIR_CRM_HI)
      && (req_in.opc2[1:0] == HMR_DIR_OPC2_LO); // R9
    tgt = HMR_TGT_NONE;
    idx = st.sel; // R14 R17
    // Even direct indices below sixteen share both opcodes with the indirect registers, so direct goes first.
    if (is_direct)
    begin
      // Indices past the implemented count decode to nothing and are refused.
      if ({1'b0, dir_idx} < HMR_NUM_HYP_REGIONS) // R8 R10
      begin
        tgt = HMR_TGT_LIM_DIR;
        idx = dir_idx;
      end
    end
    else if (req_in.coproc == HMR_CP_NUM && req_in.crn == HMR_CRN_REGION
             && req_in.opc1 == HMR_OPC1_HYP && req_in.opc2 == HMR_OPC2_HYP)
    begin
      unique case (req_in.crm)
        HMR_CRM_LIMIT: tgt = HMR_TGT_LIM_IND; // R5
        HMR_CRM_SELECT: tgt = HMR_TGT_SELECT; // R14
        HMR_CRM_ENABLE: tgt = HMR_TGT_ENABLE; // R18
        default: tgt = HMR_TGT_NONE;
      endcase
    end
    else if (req_in.coproc == HMR_CP_NUM && req_in.crn == HMR_CRN_IDENT
             && req_in.opc1 == HMR_OPC1_IDENT && req_in.opc2 == HMR_OPC2_IDENT
             && req_in.crm == HMR_CRM_IDENT)
    begin
      tgt = HMR_TGT_IDENT;
    end
  end

  // Privilege and trap resolution; with trap_general_exceptions clear, an enabled trap wins over the refusal at kernel level.
  always_comb
  begin
    kind = HMR_RESP_UNDEF;
    if (tgt == HMR_TGT_NONE)
    begin
      kind = HMR_RESP_UNDEF; // R10
    end
    else if (req_in.level == HMR_HYPERVISOR_LEVEL)
    begin
      kind = HMR_RESP_OK; // R6
    end
    else if (req_in.level == HMR_KERNEL_LEVEL && !ctrl_in.trap_general_exceptions)
    begin
      if (tgt == HMR_TGT_IDENT)
      begin
        kind = HMR_RESP_OK; // R15
      end
      else if (ctrl_in.trap_bit_six && tgt != HMR_TGT_LIM_DIR)
      begin
        kind = HMR_RESP_TRAP; // R7
      end
      else if (ctrl_in.trap_bit_ten && tgt == HMR_TGT_LIM_DIR)
      begin
        kind = HMR_RESP_TRAP; // R11
      end
      else
      begin
        kind = HMR_RESP_UNDEF; // R6
      end
    end
  end

  always_comb
  begin
    next_st = st;
    mem_we = 1'b0;
    mem_wdata = {req_in.wdata[31:HMR_LIMIT_LSB], req_in.wdata[HMR_ATTR_LSB +: 3]};
    next_st.s1_valid = req_in.valid;
    next_st.s1_read = req_in.valid && !req_in.write;
    next_st.s1_kind = kind;
    next_st.s1_tgt = tgt;
    next_st.s1_idx = idx;
    if (req_in.valid && req_in.write && kind == HMR_RESP_OK)
    begin
      unique case (tgt)
        HMR_TGT_LIM_IND, HMR_TGT_LIM_DIR:
        begin
          mem_we = 1'b1; // R8 R17
          next_st.en[idx] = req_in.wdata[HMR_EN_BIT]; // R3
          next_st.en = next_st.en & HMR_IMPL_MASK; // R18
        end
        HMR_TGT_SELECT: next_st.sel = req_in.wdata[HMR_IDX_W-1:0]; // R12 R13
        HMR_TGT_ENABLE: next_st.en = req_in.wdata & HMR_IMPL_MASK; // R18
        default: next_st.en = st.en;
      endcase
    end
    // Answer stage: memory data is one cycle old, so the answer leaves two edges after the request.
    next_st.resp.valid = st.s1_valid;
    next_st.resp.kind = st.s1_kind;
    next_st.resp.rdata = 32'h0000_0000;
    if (st.s1_read && st.s1_kind == HMR_RESP_OK)
    begin
      unique case (st.s1_tgt)
        HMR_TGT_LIM_IND, HMR_TGT_LIM_DIR:
          next_st.resp.rdata = {mem_q_a.limit, 2'b00, mem_q_a.attribute_index, st.en[st.s1_idx]}; // R4
        HMR_TGT_SELECT: next_st.resp.rdata = {27'h0, st.sel}; // R12
        HMR_TGT_ENABLE: next_st.resp.rdata = st.en; // R18
        HMR_TGT_IDENT: next_st.resp.rdata = {16'h0, HMR_NUM_EL1_REGIONS, 8'h00}; // R15 R16
        default: next_st.resp.rdata = 32'h0000_0000;
      endcase
    end
    // Lookup pipe: one region is compared per request, against the caller's base.
    next_st.l1_valid = lookup_in.valid;
    next_st.l1_addr = lookup_in.addr;
    next_st.l1_base = lookup_in.base;
    next_st.l1_region = lookup_in.region;
    next_st.hit.valid = st.l1_valid;
    next_st.hit.hit = st.l1_valid && match_hit; // R19
    next_st.hit.attr = st.l1_valid ? match_attr : 8'h00; // R2
  end

  // Enable bits and the selector reset to known values; limits and indices do not.
  always_ff @(posedge clk_sys_in or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      st <= '0;
      st.sel <= HMR_SEL_RESET;
      st.en <= HMR_EN_RESET; // R3 R4
    end
    else
    begin
      st <= next_st;
    end
  end

  hmr_limit_mem u_mem (
    .clk_sys_in(clk_sys_in),
    .we_in(mem_we),
    .addr_a_in(idx),
    .wdata_in(mem_wdata),
    .addr_b_in(lookup_in.region),
    .rdata_a_out(mem_q_a),
    .rdata_b_out(mem_q_b)
  );

  hmr_region_match u_match (
    .addr_in(st.l1_addr),
    .base_in(st.l1_base),
    .limit_in(mem_q_b),
    .enable_in(st.en[st.l1_region]),
    .attr_low_in(attr_low_in),
    .attr_high_in(attr_high_in),
    .hit_out(match_hit),
    .attr_out(match_attr)
  );

  assign resp_out = st.resp;
  assign hit_out = st.hit;
  assign region_enable_out = st.en;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_ok);

  sequence s_kernel_req;
    req_in.valid && req_in.level == HMR_KERNEL_LEVEL && !ctrl_in.trap_general_exceptions;
  endsequence

  sequence s_sel_write;
    req_in.valid && req_in.write && tgt == HMR_TGT_SELECT && req_in.level == HMR_HYPERVISOR_LEVEL;
  endsequence

  sequence s_sel_read;
    req_in.valid && !req_in.write && tgt == HMR_TGT_SELECT && req_in.level == HMR_HYPERVISOR_LEVEL;
  endsequence

  chk_user_refused: assert property ( // R6
    req_in.valid && req_in.level == HMR_USER_LEVEL |-> ##2 resp_out.valid && resp_out.kind == HMR_RESP_UNDEF)
    else $error("user level access was not refused");

  chk_six_trap: assert property ( // R7
    s_kernel_req ##0 (ctrl_in.trap_bit_six && (tgt == HMR_TGT_SELECT || tgt == HMR_TGT_LIM_IND))
    |-> ##2 resp_out.kind == HMR_RESP_TRAP)
    else $error("indirect kernel access did not trap");

  chk_ten_trap: assert property ( // R11
    s_kernel_req ##0 (ctrl_in.trap_bit_ten && tgt == HMR_TGT_LIM_DIR) |-> ##2 resp_out.kind == HMR_RESP_TRAP)
    else $error("direct kernel access did not trap");

  chk_unalloc_index: assert property ( // R10
    req_in.valid && is_direct && {1'b0, dir_idx} >= HMR_NUM_HYP_REGIONS
    |-> ##2 resp_out.kind == HMR_RESP_UNDEF)
    else $error("unimplemented direct index was accepted");

  chk_limit_reserved: assert property ( // R4
    st.s1_read && st.s1_kind == HMR_RESP_OK && st.s1_tgt == HMR_TGT_LIM_DIR |=> resp_out.rdata[5:4] == 2'b00)
    else $error("limit reserved bits read nonzero");

  chk_sel_readback: assert property ( // R12
    s_sel_write ##1 s_sel_read |-> ##2 resp_out.rdata == {27'h0, $past(req_in.wdata[HMR_IDX_W-1:0], 3)})
    else $error("selector read back wrong value");

  chk_ident_count: assert property ( // R15
    req_in.valid && !req_in.write && tgt == HMR_TGT_IDENT && kind == HMR_RESP_OK
    |-> ##2 resp_out.rdata == {16'h0, HMR_NUM_EL1_REGIONS, 8'h00})
    else $error("region count register read wrong");

  chk_enable_reset: assert property ( // R3
    $rose(rst_ok) |-> region_enable_out == HMR_EN_RESET)
    else $error("enable bits not clear after reset");

  chk_alias_mask: assert property ( // R18
    (region_enable_out & ~HMR_IMPL_MASK) == 32'h0000_0000)
    else $error("unimplemented enable bit set");

  chk_indirect_enable: assert property ( // R17
    req_in.valid && req_in.write && tgt == HMR_TGT_LIM_IND && kind == HMR_RESP_OK
    |=> region_enable_out[$past(st.sel)] == ($past(req_in.wdata[HMR_EN_BIT]) && {1'b0, $past(st.sel)} < HMR_NUM_HYP_REGIONS))
    else $error("indirect write missed the selected region");

  chk_disabled_miss: assert property ( // R3
    lookup_in.valid && !st.en[lookup_in.region] && !(req_in.valid && req_in.write)
    |-> ##2 hit_out.valid && !hit_out.hit)
    else $error("disabled region reported a hit");

endmodule

//--- hmr_core_model.sv
// Processor core model that issues coprocessor register accesses one at a time, except a selector write and read issued back to back.
`timescale 1ns/1ps
module hmr_core_model
  import hmr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire hmr_resp_s resp_in,
  output hmr_req_s req_out
);
  initial
  begin
    req_out = '0;
  end

  // The answer stands for one cycle after the second rising edge; released data is inverted so it cannot be reused.
  task automatic access(input logic wr, input logic [1:0] lvl, input logic [2:0] op1, input logic [2:0] op2,
                        input logic [3:0] crn, input logic [3:0] crm, input logic [31:0] wd,
                        output hmr_resp_s rsp);
    @(negedge clk_sys_in);
    req_out <= '{valid: 1'b1, write: wr, coproc: 4'hF, opc1: op1, opc2: op2, crn: crn, crm: crm, wdata: wd, level: lvl};
    @(negedge clk_sys_in);
    req_out.valid <= 1'b0;
    req_out.wdata <= ~wd;
    @(negedge clk_sys_in);
    rsp = resp_in;
  endtask

  // Selector write and read on consecutive edges, so the read must already see the new value.
  task automatic sel_pair(input logic [31:0] wd, output hmr_resp_s rsp_wr, output hmr_resp_s rsp_rd);
    @(negedge clk_sys_in);
    req_out <= '{valid: 1'b1, write: 1'b1, coproc: HMR_CP_NUM, opc1: HMR_OPC1_HYP, opc2: HMR_OPC2_HYP,
                 crn: HMR_CRN_REGION, crm: HMR_CRM_SELECT, wdata: wd, level: HMR_HYPERVISOR_LEVEL};
    @(negedge clk_sys_in);
    req_out.write <= 1'b0;
    req_out.wdata <= ~wd;
    @(negedge clk_sys_in);
    req_out.valid <= 1'b0;
    rsp_wr = resp_in;
    @(negedge clk_sys_in);
    rsp_rd = resp_in;
  endtask
endmodule

//--- hmr_top_tb.sv
// Self-checking bench for the hypervisor region limit block.
`timescale 1ns/1ps
module hmr_top_tb;
  import hmr_pkg::*;
  logic clk_sys_in;
  logic arst_n_in;
  hmr_req_s req;
  hmr_ctrl_s ctrl;
  hmr_lookup_s lookup;
  hmr_resp_s resp;
  hmr_hit_s hit;
  logic [31:0] region_enable;
  logic [31:0] attr_low;
  logic [31:0] attr_high;
  logic [1:0] lvl;
  hmr_resp_s rsp;
  hmr_resp_s rsp2;
  int n_mismatch;
  int cmp_count;

  hmr_top DUT (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .req_in(req), .ctrl_in(ctrl),
    .attr_low_in(attr_low), .attr_high_in(attr_high), .lookup_in(lookup), .resp_out(resp), .hit_out(hit),
    .region_enable_out(region_enable));
  hmr_core_model core (.clk_sys_in(clk_sys_in), .resp_in(resp), .req_out(req));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [2:0] op1, input logic [2:0] op2, input logic [3:0] crn,
                     input logic [3:0] crm, input logic [31:0] wd, input logic [1:0] kind, input logic [31:0] exp);
    core.access(wr, lvl, op1, op2, crn, crm, wd, rsp);
    check({29'h0, rsp.valid, rsp.kind}, {29'h0, 1'b1, kind}, "response kind");
    check(rsp.rdata, exp, "read data");
  endtask

  task automatic sel(input logic wr, input logic [31:0] wd, input logic [1:0] kind, input logic [31:0] exp);
    acc(wr, 3'h4, 3'h1, 4'h6, 4'h2, wd, kind, exp);
  endtask

  task automatic ind(input logic wr, input logic [31:0] wd, input logic [1:0] kind, input logic [31:0] exp);
    acc(wr, 3'h4, 3'h1, 4'h6, 4'h3, wd, kind, exp);
  endtask

  task automatic ena(input logic [1:0] kind, input logic [31:0] exp);
    acc(1'b0, 3'h4, 3'h1, 4'h6, 4'h1, 32'h0, kind, exp);
  endtask

  task automatic dir(input logic [4:0] n, input logic wr, input logic [31:0] wd, input logic [1:0] kind,
                     input logic [31:0] exp);
    acc(wr, {2'b10, n[4]}, {n[0], 2'b01}, 4'h6, {1'b1, n[3:1]}, wd, kind, exp);
  endtask

  task automatic look(input logic [4:0] rg, input logic [25:0] base, input logic [31:0] addr, input logic exp_hit,
                      input logic [7:0] exp_attr);
    @(negedge clk_sys_in);
    lookup <= '{valid: 1'b1, addr: addr, region: rg, base: base};
    @(negedge clk_sys_in);
    lookup.valid <= 1'b0;
    @(negedge clk_sys_in);
    check({22'h0, hit.valid, hit.hit, hit.attr}, {22'h0, 1'b1, exp_hit, exp_attr}, "lookup");
  endtask

  // Reserved bits 5:4 are written as ones so the read-back shows they are dropped.
  function automatic logic [31:0] limw(input int n);
    return {6'(n + 1), 20'h0, 2'b11, 3'(n), 1'b1};
  endfunction

  function automatic logic [31:0] limr(input int n);
    return {6'(n + 1), 20'h0, 2'b00, 3'(n), 1'b1};
  endfunction

  task automatic do_reset();
    arst_n_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    ctrl = '0;
    lookup = '0;
    attr_low = 32'h3322_1100;
    attr_high = 32'h7766_5544;
    lvl = HMR_HYPERVISOR_LEVEL;
    n_mismatch = 0;
    cmp_count = 0;
    do_reset();
    check(region_enable, 32'h0, "enables after reset");
    ena(HMR_RESP_OK, 32'h0);
    sel(1'b0, 32'h0, HMR_RESP_OK, 32'h0);
    for (int n = 0; n < 32; n++)
      dir(5'(n), 1'b1, limw(n), (n < 24) ? HMR_RESP_OK : HMR_RESP_UNDEF, 32'h0);
    for (int n = 0; n < 32; n++)
      dir(5'(n), 1'b0, 32'h0, (n < 24) ? HMR_RESP_OK : HMR_RESP_UNDEF, (n < 24) ? limr(n) : 32'h0);
    ena(HMR_RESP_OK, 32'h00FF_FFFF);
    check(region_enable, 32'h00FF_FFFF, "enable vector");
    for (int n = 0; n < 8; n++)
      look(5'(n), {6'(n), 20'h0}, {6'(n + 1), 20'h0, 6'h3F}, 1'b1, 8'(8'h11 * n));
    core.sel_pair(32'h0000_0007, rsp, rsp2);
    check({29'h0, rsp.valid, rsp.kind}, {29'h0, 1'b1, HMR_RESP_OK}, "pair write kind");
    check({29'h0, rsp2.valid, rsp2.kind}, {29'h0, 1'b1, HMR_RESP_OK}, "pair read kind");
    check(rsp2.rdata, 32'h0000_0007, "pair read data");
    sel(1'b1, 32'h5, HMR_RESP_OK, 32'h0);
    sel(1'b0, 32'h0, HMR_RESP_OK, 32'h5);
    ind(1'b0, 32'h0, HMR_RESP_OK, limr(5));
    ind(1'b1, 32'hABCD_E07A, HMR_RESP_OK, 32'h0);
    dir(5'd5, 1'b0, 32'h0, HMR_RESP_OK, 32'hABCD_E04A);
    ena(HMR_RESP_OK, 32'h00FF_FFDF);
    look(5'd5, 26'(32'hABCD_0000 >> 6), 32'hABCD_E07F, 1'b0, 8'h55);
    ind(1'b1, 32'hABCD_E07B, HMR_RESP_OK, 32'h0);
    look(5'd5, 26'(32'hABCD_0000 >> 6), 32'hABCD_E07F, 1'b1, 8'h55);
    look(5'd5, 26'(32'hABCD_0000 >> 6), 32'hABCD_E080, 1'b0, 8'h55);
    look(5'd5, 26'(32'hABCD_0000 >> 6), 32'hABCD_0000, 1'b1, 8'h55);
    look(5'd5, 26'(32'hABCD_0000 >> 6), 32'hABCC_FFFF, 1'b0, 8'h55);
    lvl = HMR_USER_LEVEL;
    sel(1'b0, 32'h0, HMR_RESP_UNDEF, 32'h0);
    lvl = 2'b11;
    sel(1'b0, 32'h0, HMR_RESP_UNDEF, 32'h0);
    lvl = HMR_KERNEL_LEVEL;
    ctrl.trap_general_exceptions = 1'b1;
    sel(1'b0, 32'h0, HMR_RESP_UNDEF, 32'h0);
    ctrl = '0;
    sel(1'b1, 32'h2, HMR_RESP_UNDEF, 32'h0);
    dir(5'd3, 1'b0, 32'h0, HMR_RESP_UNDEF, 32'h0);
    ctrl.trap_bit_six = 1'b1;
    sel(1'b1, 32'h2, HMR_RESP_TRAP, 32'h0);
    ind(1'b0, 32'h0, HMR_RESP_TRAP, 32'h0);
    dir(5'd3, 1'b0, 32'h0, HMR_RESP_UNDEF, 32'h0);
    ctrl = '0;
    ctrl.trap_bit_ten = 1'b1;
    dir(5'd3, 1'b1, 32'h0, HMR_RESP_TRAP, 32'h0);
    ind(1'b0, 32'h0, HMR_RESP_UNDEF, 32'h0);
    ctrl = '0;
    acc(1'b0, 3'h0, 3'h4, 4'h0, 4'h0, 32'h0, HMR_RESP_OK, 32'h0000_1000);
    lvl = HMR_HYPERVISOR_LEVEL;
    sel(1'b0, 32'h0, HMR_RESP_OK, 32'h5);
    dir(5'd3, 1'b0, 32'h0, HMR_RESP_OK, limr(3));
    acc(1'b1, 3'h0, 3'h4, 4'h0, 4'h0, 32'hFFFF_FFFF, HMR_RESP_OK, 32'h0);
    acc(1'b0, 3'h0, 3'h4, 4'h0, 4'h0, 32'h0, HMR_RESP_OK, 32'h0000_1000);
    acc(1'b0, 3'h4, 3'h1, 4'h6, 4'h4, 32'h0, HMR_RESP_UNDEF, 32'h0);
    do_reset();
    check(region_enable, 32'h0, "enables after second reset");
    ena(HMR_RESP_OK, 32'h0);
    complete_run();
  end
endmodule
